// file: rtl/tx_cfg_map.svh
/*
  offsets, field positions, reset values and counts of the transmit configuration bank.
  assumes a 12-bit byte address: port number in bits 11:9, register offset in bits 8:0.
*/
`ifndef TX_CFG_MAP_SVH
`define TX_CFG_MAP_SVH

`define NUM_PORTS          8
`define PORT_STRIDE        12'h200
`define OFS_CONTROL_THREE  9'h183
`define OFS_IO_CONFIG      9'h184
`define OFS_STORE_CONTROL  9'h185
`define OFS_ALARM_CODE     9'h186
`define OFS_HDLC_FIFO      9'h187
`define OFS_INTERLEAVE     9'h188

`define RST_CONTROL_THREE  8'h00
`define RST_IO_CONFIG      8'h00
`define RST_STORE_CONTROL  8'h00
`define RST_ALARM_CODE     8'h00
`define RST_HDLC_FIFO      8'h00
`define RST_INTERLEAVE     8'h00

`define MASK_CONTROL_THREE 8'hff
`define MASK_IO_CONFIG     8'hff
`define MASK_STORE_CONTROL 8'hdf
`define MASK_ALARM_CODE    8'h0f
`define MASK_HDLC_FIFO     8'h03
`define MASK_INTERLEAVE    8'h7f

`define B3_MF_REF          3
`define B3_FRAME_FORMAT    2
`define B3_VIOLATION       1
`define B3_LOOP_OR_CRC     0
`define BIO_CLK_INV        7
`define BIO_LSYNC_INV      6
`define BIO_SSYNC_INV      5
`define BIO_CLK_RATE       4
`define BIO_SSYNC_MODE     3
`define BIO_SYNC_DIR       2
`define BIO_DOUBLE_WIDE    1
`define BIO_LSYNC_MODE     0
`define BES_DATA_FMT       7
`define BES_GAP_CLK        6
`define BES_SLIP_ZONE      4
`define BES_ALIGN          3
`define BES_PTR_RESET      2
`define BES_MIN_DELAY      1
`define BES_ENABLE         0
`define BAC_RAI_MODE       3
`define BAC_AIS_MODE       2
`define BIB_TYPE           4
`define BIB_ENABLE         3

`define T1_FRAME_BITS      9'd193
`define E1_FRAME_BITS      9'd256
`define ESF_FRAMES         5'd24
`define D4_FRAMES          5'd12
`define E1_MF_FRAMES       5'd16
`define SLIP_ZONE_WIDE     8'd9
`define SLIP_ZONE_NARROW   8'd2
`define T1_HALF_FRAME      8'd12
`define E1_HALF_FRAME      8'd16
`define WM_CODE0           6'd4
`define WM_CODE1           6'd16
`define WM_CODE2           6'd32
`define WM_CODE3           6'd48
`define BUS_DEV_CODE0      4'd2
`define BUS_DEV_CODE1      4'd4
`define BUS_DEV_CODE2      4'd8

`endif

// file: rtl/tx_cfg_pkg.sv
/*
  types of the transmit configuration bank.
  assumes tx_cfg_map.svh supplies the numbers.
*/
package tx_cfg_pkg;

  typedef enum logic [2:0] {
    ALM_NONE,
    ALM_RAI,
    ALM_RAI_CI,
    ALM_AIS,
    ALM_AIS_CI
  } alarm_t;

  typedef struct packed {
    logic       mf_ref_sys;
    logic       d4_framing;
    logic       loop_code_on;
    logic       crc_recalc;
    logic       clk_rate_high;
    logic       sys_sync_mf;
    logic       line_sync_mf;
    logic       data_56k;
    logic       gapped_clock;
    logic       store_on;
    logic       store_min_delay;
    logic [1:0] loop_len;
    logic [5:0] lwm_bytes;
    logic       ibo_on;
    logic       ibo_frame;
    logic [3:0] ibo_devices;
    logic [2:0] bus_position;
  } port_cfg_t;

  typedef struct packed {
    logic bpv_insert;
    logic store_align;
    logic store_reset;
    logic force_slip;
    logic mf_boundary;
  } port_evt_t;

endpackage : tx_cfg_pkg

// file: rtl/transmit_path_config_regs.sv
/*
  eight-port transmit configuration bank with sync/clock pin handling and command pulses.
  assumes a same-clock register port, external pins asynchronous to sys_clk,
  framer datapath consuming cfg/event outputs.
*/
`timescale 1ns/1ns
`include "tx_cfg_map.svh"

module transmit_path_config_regs (
  input  wire  logic                              sys_clk,
  input  wire  logic                              arst_n,
  input  wire  logic [11:0]                       addr,
  input  wire  logic [7:0]                        wr_data,
  input  wire  logic                              wr_stb,
  input  wire  logic                              rd_stb,
  output logic [7:0]                              rd_data,
  input  wire  logic [7:0]                        e1_mode,
  input  wire  logic [7:0]                        rate_conv,
  input  wire  logic [7:0]                        remote_alarm_request,
  input  wire  logic [7:0]                        ais_request,
  input  wire  logic [7:0]                        three_ones_seen,
  input  wire  logic [7:0][7:0]                   store_separation,
  input  wire  logic [7:0]                        line_clock_pin,
  input  wire  logic [7:0]                        line_sync_pin_in,
  output logic [7:0]                              line_sync_pin_out,
  output logic [7:0]                              line_sync_pin_oe_n,
  input  wire  logic [7:0]                        system_sync_pin,
  output tx_cfg_pkg::port_cfg_t [7:0]             port_cfg,
  output tx_cfg_pkg::port_evt_t [7:0]             port_evt,
  output tx_cfg_pkg::alarm_t [7:0]                alarm_sel
);
  import tx_cfg_pkg::*;

  logic [7:0]       lclk_s1_r;
  logic [7:0]       lclk_s2_r;
  logic [7:0]       lsync_s1_r;
  logic [7:0]       lsync_s2_r;
  logic [7:0]       ssync_s1_r;
  logic [7:0]       ssync_s2_r;
  logic [7:0][7:0]  port_rd;
  logic [7:0]       rd_data_nxt;
  logic [8:0]       reg_ofs;

  assign reg_ofs = addr[8:0];

  // pins cross into sys_clk through two flops each
  // only the second stage feeds logic; the first may still be settling
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lclk_s1_r  <= 8'h00;
      lclk_s2_r  <= 8'h00;
    end else begin
      lclk_s1_r  <= line_clock_pin;
      lclk_s2_r  <= lclk_s1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lsync_s1_r <= 8'h00;
      lsync_s2_r <= 8'h00;
    end else begin
      lsync_s1_r <= line_sync_pin_in;
      lsync_s2_r <= lsync_s1_r;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ssync_s1_r <= 8'h00;
      ssync_s2_r <= 8'h00;
    end else begin
      ssync_s1_r <= system_sync_pin;
      ssync_s2_r <= ssync_s1_r;
    end
  end

  // unmapped offsets read zero
  always_comb begin
    rd_data_nxt = port_rd[addr[11:9]];
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data <= 8'h00;
    end else if (rd_stb) begin
      rd_data <= rd_data_nxt;
    end else begin
      rd_data <= 8'h00;
    end
  end

  for (genvar p = 0; p < `NUM_PORTS; p++) begin : g_port
    logic [7:0] ctl3_r;
    logic [7:0] io_r;
    logic [7:0] es_r;
    logic [7:0] ac_r;
    logic [7:0] hf_r;
    logic [7:0] ib_r;
    logic       wr_port;
    logic       lclk_d_r;
    logic       lsync_d_r;
    logic       ssync_d_r;
    logic       lclk;
    logic       lsync;
    logic       ssync;
    logic       lclk_rise;
    logic       lsync_rise;
    logic       ssync_rise;
    logic [8:0] bit_cnt_r;
    logic [4:0] frm_cnt_r;
    logic [8:0] frame_bits;
    logic [4:0] mf_frames;
    logic       bit_wrap;
    logic       frm_wrap;
    logic       bpv_pend_r;
    logic [7:0] slip_thr;
    logic [7:0] half_frame;
    logic       ext_align;
    logic       sync_pulse;
    logic       sig_frame;

    assign wr_port = wr_stb && (addr[11:9] == 3'(p));

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        ctl3_r <= `RST_CONTROL_THREE;
        io_r   <= `RST_IO_CONFIG;
        es_r   <= `RST_STORE_CONTROL;
        ac_r   <= `RST_ALARM_CODE;
        hf_r   <= `RST_HDLC_FIFO;
        ib_r   <= `RST_INTERLEAVE;
      end else if (wr_port) begin
        unique case (reg_ofs)
          `OFS_CONTROL_THREE: ctl3_r <= wr_data & `MASK_CONTROL_THREE;
          `OFS_IO_CONFIG:     io_r   <= wr_data & `MASK_IO_CONFIG;
          `OFS_STORE_CONTROL: es_r   <= wr_data & `MASK_STORE_CONTROL;
          `OFS_ALARM_CODE:    ac_r   <= wr_data & `MASK_ALARM_CODE;
          `OFS_HDLC_FIFO:     hf_r   <= wr_data & `MASK_HDLC_FIFO;
          `OFS_INTERLEAVE:    ib_r   <= wr_data & `MASK_INTERLEAVE;
          default: ;
        endcase
      end
    end

    always_comb begin
      unique case (reg_ofs)
        `OFS_CONTROL_THREE: port_rd[p] = ctl3_r;
        `OFS_IO_CONFIG:     port_rd[p] = io_r;
        `OFS_STORE_CONTROL: port_rd[p] = es_r;
        `OFS_ALARM_CODE:    port_rd[p] = ac_r;
        `OFS_HDLC_FIFO:     port_rd[p] = hf_r;
        `OFS_INTERLEAVE:    port_rd[p] = ib_r;
        default:            port_rd[p] = 8'h00;
      endcase
    end

    // decoded configuration, registered so outputs leave from flops
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_cfg[p] <= '0;
      end else begin
        port_cfg[p].mf_ref_sys      <= ctl3_r[`B3_MF_REF];
        port_cfg[p].d4_framing      <= !e1_mode[p] && ctl3_r[`B3_FRAME_FORMAT];
        port_cfg[p].loop_code_on    <= !e1_mode[p] && ctl3_r[`B3_LOOP_OR_CRC];
        port_cfg[p].crc_recalc      <= e1_mode[p] && ctl3_r[`B3_LOOP_OR_CRC];
        port_cfg[p].clk_rate_high   <= io_r[`BIO_CLK_RATE];
        port_cfg[p].sys_sync_mf     <= io_r[`BIO_SSYNC_MODE];
        port_cfg[p].line_sync_mf    <= io_r[`BIO_LSYNC_MODE];
        port_cfg[p].data_56k        <= es_r[`BES_DATA_FMT];
        port_cfg[p].gapped_clock    <= es_r[`BES_GAP_CLK];
        port_cfg[p].store_on        <= es_r[`BES_ENABLE];
        port_cfg[p].store_min_delay <= es_r[`BES_ENABLE] && es_r[`BES_MIN_DELAY];
        port_cfg[p].loop_len        <= ac_r[1:0];
        unique case (hf_r[1:0])
          2'b00: port_cfg[p].lwm_bytes <= `WM_CODE0;
          2'b01: port_cfg[p].lwm_bytes <= `WM_CODE1;
          2'b10: port_cfg[p].lwm_bytes <= `WM_CODE2;
          2'b11: port_cfg[p].lwm_bytes <= `WM_CODE3;
        endcase
        port_cfg[p].ibo_on          <= ib_r[`BIB_ENABLE];
        port_cfg[p].ibo_frame       <= ib_r[`BIB_TYPE];
        unique case (ib_r[6:5])
          2'b00:   port_cfg[p].ibo_devices <= `BUS_DEV_CODE0;
          2'b01:   port_cfg[p].ibo_devices <= `BUS_DEV_CODE1;
          2'b10:   port_cfg[p].ibo_devices <= `BUS_DEV_CODE2;
          default: port_cfg[p].ibo_devices <= 4'h0;
        endcase
        port_cfg[p].bus_position    <= ib_r[2:0];
      end
    end

    // alarm pattern choice; AIS outranks RAI since it overwrites framing
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        alarm_sel[p] <= ALM_NONE;
      end else if (!e1_mode[p] && ais_request[p]) begin
        alarm_sel[p] <= ac_r[`BAC_AIS_MODE] ? ALM_AIS_CI : ALM_AIS;
      end else if (!e1_mode[p] && !ctl3_r[`B3_FRAME_FORMAT] && remote_alarm_request[p]) begin
        alarm_sel[p] <= ac_r[`BAC_RAI_MODE] ? ALM_RAI_CI : ALM_RAI;
      end else begin
        alarm_sel[p] <= ALM_NONE;
      end
    end

    // pin polarity, each of the three pins inverted by its own io_r bit
    assign lclk  = lclk_s2_r[p] ^ io_r[`BIO_CLK_INV];
    assign lsync = lsync_s2_r[p] ^ io_r[`BIO_LSYNC_INV];
    assign ssync = ssync_s2_r[p] ^ io_r[`BIO_SSYNC_INV];

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        lclk_d_r  <= 1'b0;
      end else begin
        lclk_d_r  <= lclk;
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        lsync_d_r <= 1'b0;
      end else begin
        lsync_d_r <= lsync;
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        ssync_d_r <= 1'b0;
      end else begin
        ssync_d_r <= ssync;
      end
    end

    assign lclk_rise  = lclk && !lclk_d_r;
    assign lsync_rise = lsync && !lsync_d_r && !io_r[`BIO_SYNC_DIR];
    assign ssync_rise = ssync && !ssync_d_r;
    assign frame_bits = e1_mode[p] ? `E1_FRAME_BITS : `T1_FRAME_BITS;
    assign mf_frames  = e1_mode[p] ? `E1_MF_FRAMES :
                        (ctl3_r[`B3_FRAME_FORMAT] ? `D4_FRAMES : `ESF_FRAMES);
    assign bit_wrap   = (bit_cnt_r == frame_bits - 9'd1);
    assign frm_wrap   = (frm_cnt_r == mf_frames - 5'd1);

    // line-side frame and multiframe counters
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        bit_cnt_r <= 9'h000;
        frm_cnt_r <= 5'h00;
      end else if (lsync_rise && !ctl3_r[`B3_MF_REF]) begin
        bit_cnt_r <= 9'h000;
        if (io_r[`BIO_LSYNC_MODE]) begin
          frm_cnt_r <= 5'h00;
        end
      end else if (ctl3_r[`B3_MF_REF] && ssync_rise) begin
        bit_cnt_r <= 9'h000;
        if (io_r[`BIO_SSYNC_MODE]) begin
          frm_cnt_r <= 5'h00;
        end
      end else if (lclk_rise) begin
        bit_cnt_r <= bit_wrap ? 9'h000 : bit_cnt_r + 9'd1;
        if (bit_wrap) begin
          frm_cnt_r <= frm_wrap ? 5'h00 : frm_cnt_r + 5'd1;
        end
      end
    end

    // T1 signaling frames 6 and 12 of each group of twelve
    assign sig_frame  = !e1_mode[p] && (frm_cnt_r == 5'd5 || frm_cnt_r == 5'd11 ||
                        frm_cnt_r == 5'd17 || frm_cnt_r == 5'd23);
    assign sync_pulse = (io_r[`BIO_LSYNC_MODE] ? frm_cnt_r == 5'h00 : 1'b1) &&
                        (bit_cnt_r == 9'h000 ||
                         (bit_cnt_r == 9'd1 && io_r[`BIO_DOUBLE_WIDE] && sig_frame));

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        line_sync_pin_out[p]  <= 1'b0;
        line_sync_pin_oe_n[p] <= 1'b1;
      end else begin
        line_sync_pin_oe_n[p] <= !io_r[`BIO_SYNC_DIR];
        line_sync_pin_out[p]  <= io_r[`BIO_SYNC_DIR] && (sync_pulse ^ io_r[`BIO_LSYNC_INV]);
      end
    end

    // elastic store thresholds
    assign slip_thr   = es_r[`BES_SLIP_ZONE] ? `SLIP_ZONE_NARROW : `SLIP_ZONE_WIDE;
    assign half_frame = e1_mode[p] ? `E1_HALF_FRAME : `T1_HALF_FRAME;
    assign ext_align  = store_separation[p] < half_frame;

    // a set in the clearing cycle wins, so a late three-ones match never eats a new request
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        bpv_pend_r <= 1'b0;
      end else if (wr_port && reg_ofs == `OFS_CONTROL_THREE &&
                   wr_data[`B3_VIOLATION] && !ctl3_r[`B3_VIOLATION]) begin
        bpv_pend_r <= 1'b1;
      end else if (three_ones_seen[p]) begin
        bpv_pend_r <= 1'b0;
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_evt[p].bpv_insert  <= 1'b0;
      end else begin
        port_evt[p].bpv_insert  <= bpv_pend_r && three_ones_seen[p];
      end
    end

    // commands compare against the stored bit, so rewriting a 1 never refires
    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_evt[p].store_align <= 1'b0;
      end else begin
        port_evt[p].store_align <= wr_port && reg_ofs == `OFS_STORE_CONTROL &&
                                   wr_data[`BES_ALIGN] && !es_r[`BES_ALIGN] &&
                                   es_r[`BES_ENABLE] && ext_align;
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_evt[p].store_reset <= 1'b0;
      end else begin
        port_evt[p].store_reset <= wr_port && reg_ofs == `OFS_STORE_CONTROL &&
                                   wr_data[`BES_PTR_RESET] && !es_r[`BES_PTR_RESET] &&
                                   es_r[`BES_ENABLE];
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_evt[p].force_slip  <= 1'b0;
      end else begin
        port_evt[p].force_slip  <= rate_conv[p] && es_r[`BES_ENABLE] &&
                                   store_separation[p] <= slip_thr;
      end
    end

    always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
        port_evt[p].mf_boundary <= 1'b0;
      end else begin
        port_evt[p].mf_boundary <= ctl3_r[`B3_MF_REF] ? ssync_rise :
                                   (lclk_rise && bit_wrap && frm_wrap);
      end
    end
  end

endmodule : transmit_path_config_regs

// file: tb/tx_cfg_props.sv
/*
  port-level checks of the transmit configuration bank.
  assumes bind into the bank; writes to one register are not repeated two cycles apart.
*/
`timescale 1ns/1ns

module tx_cfg_props import tx_cfg_pkg::*; (
  input wire logic                         sys_clk,
  input wire logic                         arst_n,
  input wire logic [11:0]                  addr,
  input wire logic [7:0]                   wr_data,
  input wire logic                         wr_stb,
  input wire logic                         rd_stb,
  input wire logic [7:0]                   rd_data,
  input wire logic [7:0]                   rate_conv,
  input wire logic [7:0]                   ais_request,
  input wire logic [7:0]                   three_ones_seen,
  input wire logic [7:0][7:0]              store_separation,
  input wire logic [7:0]                   line_sync_pin_oe_n,
  input wire tx_cfg_pkg::port_cfg_t [7:0]  port_cfg,
  input wire tx_cfg_pkg::port_evt_t [7:0]  port_evt,
  input wire tx_cfg_pkg::alarm_t [7:0]     alarm_sel
);
  logic       w1_v, w2_v;
  logic [2:0] w1_p, w2_p;
  logic [8:0] w1_o, w2_o;
  logic [7:0] w1_d, w2_d;

  // write seen two edges back, when its decode must show
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      {w1_v, w1_p, w1_o, w1_d} <= '0;
      {w2_v, w2_p, w2_o, w2_d} <= '0;
    end else begin
      {w1_v, w1_p, w1_o, w1_d} <= {wr_stb, addr, wr_data};
      {w2_v, w2_p, w2_o, w2_d} <= {w1_v, w1_p, w1_o, w1_d};
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_read_idle: assert property (!$past(rd_stb) |-> rd_data == 8'h00)
    else $error("read data outside read slot");
  a_dir_oe: assert property (w2_v && w2_o == 9'h184 |-> line_sync_pin_oe_n[w2_p] == !w2_d[2])
    else $error("sync pin direction wrong");
  a_store_mode: assert property (w2_v && w2_o == 9'h185 |->
    {port_cfg[w2_p].store_min_delay, port_cfg[w2_p].store_on} == {w2_d[1] & w2_d[0], w2_d[0]})
    else $error("store mode wrong");
  a_watermark_code: assert property (w2_v && w2_o == 9'h187 |-> port_cfg[w2_p].lwm_bytes ==
    (w2_d[1] ? (w2_d[0] ? 6'd48 : 6'd32) : (w2_d[0] ? 6'd16 : 6'd4)))
    else $error("watermark decode wrong");
  a_bus_fields: assert property (w2_v && w2_o == 9'h188 |->
    {port_cfg[w2_p].ibo_frame, port_cfg[w2_p].ibo_on, port_cfg[w2_p].bus_position} == w2_d[4:0])
    else $error("interleave fields wrong");
  a_bus_size: assert property (w2_v && w2_o == 9'h188 && w2_d[6:5] != 2'b11 |-> port_cfg[w2_p].ibo_devices ==
    (w2_d[6] ? 4'd8 : (w2_d[5] ? 4'd4 : 4'd2)))
    else $error("bus size wrong");

  for (genvar i = 0; i < 8; i++) begin : g_port
    a_bpv_cause: assert property (port_evt[i].bpv_insert |-> $past(three_ones_seen[i]))
      else $error("violation without three ones");
    a_align_gate: assert property (port_evt[i].store_align |-> $past(store_separation[i]) < 8'd16)
      else $error("align at wide separation");
    a_reset_pulse: assert property (port_evt[i].store_reset |=> !port_evt[i].store_reset)
      else $error("store reset not a pulse");
    a_slip_idle: assert property (!rate_conv[i] && !$past(rate_conv[i]) |-> !port_evt[i].force_slip)
      else $error("slip without rate conversion");
    a_ais_cause: assert property (alarm_sel[i] inside {ALM_AIS, ALM_AIS_CI} |-> $past(ais_request[i]))
      else $error("ais without request");
  end

  c_bpv: cover property (port_evt[2].bpv_insert);
  c_align: cover property (port_evt[3].store_align);
  c_slip: cover property (port_evt[3].force_slip);
endmodule : tx_cfg_props

// file: tb/tx_far_side.sv
/*
  backplane and line clock model: free line clock, periodic system sync.
  assumes sys_clk at 100 ns.
*/
`timescale 1ns/1ns

module tx_far_side (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  output logic [7:0]      line_clock_pin,
  output logic [7:0]      system_sync_pin
);
  logic [7:0] cnt_r;

  // phase offset keeps it unrelated to sys_clk
  initial begin
    line_clock_pin = 8'h00;
    #137;
    forever #400 line_clock_pin = ~line_clock_pin;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) cnt_r <= 8'h00;
    else cnt_r <= cnt_r + 8'h01;
  end

  // four-cycle sync every 256 cycles, one rise per period
  assign system_sync_pin = {8{cnt_r < 8'h04}};
endmodule : tx_far_side

// file: tb/transmit_path_config_regs_tb_top.sv
/*
  directed bench of the transmit configuration bank.
  assumes tx_far_side drives line clock and system sync; line sync pins idle low.
*/
`timescale 1ns/1ns

module transmit_path_config_regs_tb_top;
  import tx_cfg_pkg::*;
  logic sys_clk, arst_n, wr_stb, rd_stb;
  logic [11:0] addr;
  logic [7:0] wr_data, rd_data, e1_mode, rate_conv, remote_alarm_request, ais_request;
  logic [7:0] three_ones_seen, line_clock_pin, line_sync_pin_out, line_sync_pin_oe_n, system_sync_pin;
  logic [7:0][7:0] store_separation;
  wire [7:0] line_sync_pin_in;
  port_cfg_t [7:0] port_cfg;
  port_evt_t [7:0] port_evt;
  alarm_t [7:0] alarm_sel;
  int n_fail, comparisons, n_bpv, n_al, n_rs, n_mf, n_ls;
  bit ls_q;

  // wire level: device drives when enabled, else far side holds low
  assign line_sync_pin_in = ~line_sync_pin_oe_n & line_sync_pin_out;

  transmit_path_config_regs transmit_path_config_regs_inst (.sys_clk, .arst_n, .addr, .wr_data, .wr_stb,
    .rd_stb, .rd_data, .e1_mode, .rate_conv, .remote_alarm_request, .ais_request, .three_ones_seen,
    .store_separation, .line_clock_pin, .line_sync_pin_in, .line_sync_pin_out, .line_sync_pin_oe_n,
    .system_sync_pin, .port_cfg, .port_evt, .alarm_sel);
  tx_far_side tx_far_side_inst (.sys_clk, .arst_n, .line_clock_pin, .system_sync_pin);

  always @(posedge sys_clk) begin
    n_bpv += port_evt[2].bpv_insert;
    n_al += port_evt[3].store_align;
    n_rs += port_evt[3].store_reset;
    n_mf += port_evt[5].mf_boundary;
    n_ls += line_sync_pin_out[5] && !ls_q;
    ls_q = line_sync_pin_out[5];
  end

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : wt

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wr_data <= d;
    wr_stb <= 1'b1;
    @(posedge sys_clk);
    wr_stb <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge sys_clk);
    rd_stb <= 1'b0;
    #1 chk("rd_data", rd_data, e);
  endtask : rd

  task automatic t_regs;
    logic [8:0] ofs [6] = '{9'h183, 9'h184, 9'h185, 9'h186, 9'h187, 9'h188};
    logic [7:0] msk [6] = '{8'hff, 8'hff, 8'hdf, 8'h0f, 8'h03, 8'h7f};
    for (int p = 0; p < 8; p++) begin
      for (int r = 0; r < 6; r++) begin
        rd({p[2:0], ofs[r]}, 8'h00);
        wr({p[2:0], ofs[r]}, 8'hff);
        rd({p[2:0], ofs[r]}, msk[r]);
      end
    end
    wt(2);
    chk("oe_n", line_sync_pin_oe_n, 8'h00);
    wr(12'h189, 8'hff);
    rd(12'h189, 8'h00);
    for (int p = 0; p < 8; p++) begin
      for (int r = 0; r < 6; r++) wr({p[2:0], ofs[r]}, 8'h00);
    end
    wt(2);
    chk("oe_n", line_sync_pin_oe_n, 8'hff);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_codes;
    logic [5:0] wm [4] = '{6'd4, 6'd16, 6'd32, 6'd48};
    logic [3:0] bs [3] = '{4'd2, 4'd4, 4'd8};
    logic [1:0] sz;
    port_cfg_t q;
    for (int c = 0; c < 4; c++) begin
      sz = (c == 3) ? 2'b00 : c[1:0]; // reserved size code left out
      wr(12'hd83, {5'h00, c[0], 1'b0, c[1]});
      wr(12'hd84, {3'h0, c[1], c[0], 2'b00, c[1]});
      wr(12'hd85, {c[1], c[0], 4'h0, c[1], c[0]});
      wr(12'hd86, {6'h00, c[1:0]});
      wr(12'hd87, {6'h00, c[1:0]});
      wr(12'hd88, {1'b0, sz, c[1], c[0], c[1], c[1], c[0]});
      wt(2);
      q = port_cfg[6];
      chk("d4", q.d4_framing, c[0]);
      chk("loop", q.loop_code_on, c[1]);
      chk("rate", q.clk_rate_high, c[1]);
      chk("sync_mode", {q.sys_sync_mf, q.line_sync_mf}, {c[0], c[1]});
      chk("format", {q.data_56k, q.gapped_clock}, {c[1], c[0]});
      chk("depth", {q.store_min_delay, q.store_on}, {c[1] & c[0], c[0]});
      chk("len", q.loop_len, c[1:0]);
      chk("wm", q.lwm_bytes, wm[c]);
      chk("size", q.ibo_devices, bs[sz]);
      chk("ibo", {q.ibo_frame, q.ibo_on}, {c[1], c[0]});
      chk("pos", q.bus_position, {c[1], c[1], c[0]});
    end
    e1_mode[6] <= 1'b1;
    wr(12'hd83, 8'h05);
    wt(2);
    chk("e1", {port_cfg[6].crc_recalc, port_cfg[6].loop_code_on, port_cfg[6].d4_framing}, 3'b100);
    e1_mode[6] <= 1'b0;
    $display("t_codes done");
  endtask : t_codes

  task automatic ones_pulse;
    @(posedge sys_clk);
    three_ones_seen[2] <= 1'b1;
    @(posedge sys_clk);
    three_ones_seen[2] <= 1'b0;
    wt(3);
  endtask : ones_pulse

  task automatic t_bpv;
    wr(12'h583, 8'h02);
    wt(2);
    n_bpv = 0;
    ones_pulse();
    chk("bpv_first", n_bpv, 8'd1);
    ones_pulse();
    chk("bpv_held", n_bpv, 8'd1);
    wr(12'h583, 8'h02);
    ones_pulse();
    chk("bpv_no_rise", n_bpv, 8'd1);
    wr(12'h583, 8'h00);
    wr(12'h583, 8'h02);
    ones_pulse();
    chk("bpv_again", n_bpv, 8'd2);
    $display("t_bpv done");
  endtask : t_bpv

  task automatic sep_slip(input logic [7:0] s, input logic [7:0] e);
    @(posedge sys_clk);
    store_separation[3] <= s;
    wt(4);
    chk("slip", port_evt[3].force_slip, e);
  endtask : sep_slip

  task automatic t_store;
    store_separation[3] <= 8'd12;
    wr(12'h785, 8'h01);
    wt(2);
    n_al = 0;
    n_rs = 0;
    wr(12'h785, 8'h09);
    wt(3);
    chk("align_half", n_al, 8'd0);
    wr(12'h785, 8'h01);
    store_separation[3] <= 8'd11;
    wr(12'h785, 8'h09);
    wt(3);
    chk("align_short", n_al, 8'd1);
    wr(12'h785, 8'h0d);
    wt(3);
    chk("reset", {n_rs[3:0], n_al[3:0]}, 8'h11);
    wr(12'h785, 8'h00);
    wr(12'h785, 8'h04);
    wt(3);
    chk("reset_bypass", n_rs, 8'd1);
    rate_conv[3] <= 1'b1;
    wr(12'h785, 8'h01);
    sep_slip(8'd9, 8'h01);
    sep_slip(8'd10, 8'h00);
    wr(12'h785, 8'h11);
    sep_slip(8'd2, 8'h01);
    sep_slip(8'd3, 8'h00);
    rate_conv[3] <= 1'b0;
    sep_slip(8'd2, 8'h00);
    $display("t_store done");
  endtask : t_store

  task automatic t_alarm;
    ais_request[4] <= 1'b1;
    wt(3);
    chk("ais", alarm_sel[4], ALM_AIS);
    wr(12'h986, 8'h04);
    wt(3);
    chk("ais_ci", alarm_sel[4], ALM_AIS_CI);
    ais_request[4] <= 1'b0;
    remote_alarm_request[4] <= 1'b1;
    wr(12'h986, 8'h08);
    wt(3);
    chk("rai_ci", alarm_sel[4], ALM_RAI_CI);
    wr(12'h986, 8'h00);
    wt(3);
    chk("rai", alarm_sel[4], ALM_RAI);
    remote_alarm_request[4] <= 1'b0;
    wt(3);
    chk("none", alarm_sel[4], ALM_NONE);
    $display("t_alarm done");
  endtask : t_alarm

  task automatic t_pins;
    wr(12'hb85, 8'h01);
    wr(12'hb83, 8'h08);
    wt(4);
    n_mf = 0;
    wt(512);
    chk("mf_sys", n_mf, 8'd2);
    wr(12'hb83, 8'h00);
    wr(12'hb84, 8'h04);
    wt(4);
    n_ls = 0;
    wt(3088);
    chk("line_sync", n_ls, 8'd2);
    $display("t_pins done");
  endtask : t_pins

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  initial begin
    #3000000;
    n_fail++;
    stop_test();
  end

  initial begin
    {arst_n, wr_stb, rd_stb, addr, wr_data, e1_mode, rate_conv} = '0;
    {remote_alarm_request, ais_request, three_ones_seen} = '0;
    store_separation = {8{8'h40}};
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    t_regs();
    t_codes();
    t_bpv();
    t_store();
    t_alarm();
    t_pins();
    stop_test();
  end
endmodule : transmit_path_config_regs_tb_top

bind transmit_path_config_regs tx_cfg_props tx_cfg_props_inst (.sys_clk, .arst_n, .addr, .wr_data, .wr_stb,
  .rd_stb, .rd_data, .rate_conv, .ais_request, .three_ones_seen, .store_separation, .line_sync_pin_oe_n,
  .port_cfg, .port_evt, .alarm_sel);
